// ### verilog/arsf_top.sv
// Result registers and status flags of the converter, with APB slave
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Data-ready clears only on a last-result read, never on a channel read.
// - Data-ready rises only when a new result is really stored.
// - A conversion end on an enabled channel sets data-ready even during a channel read.
// - A conversion end during another channel's disable still stores and sets data-ready.
// - Global overrun sets on a conversion end with data-ready set, status read clears it, set wins.
// - Global overrun still sets when a channel read coincides with such an overrun conversion.
// - Channel and global overrun both rise when another channel's disable coincides with an overrun end.
// - A channel done flag clears on its own result read or the last-result read.
// - Each channel overrun flag clears on any status read without an overrun end on that channel, even one coinciding with a done set.
// - A channel disabled during its conversion never gets its done flag raised.
// - A channel result read clears only that channel's done flag.
// - A sleep request while idle takes effect only when a conversion finishes.
module arsf_top (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic conv_done, // Core: conversion end pulse
  input wire logic [2:0] conv_ch, // Core: channel converted
  input wire logic [arsf_pkg::DW-1:0] conv_data, // Core: result
  input wire logic conv_busy, // Core: conversion running
  output logic conv_start, // Pulse to start a conversion
  output logic sleep_active, // Core held asleep
  output logic irq // Level interrupt
);
  logic [arsf_pkg::NCH-1:0] ch_en;
  logic [arsf_pkg::NCH-1:0] done_flag;
  logic [arsf_pkg::NCH-1:0] channel_overrun_flag;
  logic data_ready_flag;
  logic global_overrun_flag;
  logic [arsf_pkg::DW-1:0] res [arsf_pkg::NCH];
  logic [arsf_pkg::DW-1:0] last_result_reg;
  logic [2:0] last_ch;
  logic sleep_req;
  logic [arsf_pkg::IRQ_W-1:0] int_stat;
  logic [arsf_pkg::IRQ_W-1:0] int_mask;
  logic acc, wr, rd;
  logic rd_last, rd_sr, rd_chres;
  logic [2:0] rd_idx;
  logic store;
  logic [arsf_pkg::NCH-1:0] dis_mask;
  logic [arsf_pkg::NCH-1:0] end_vec;
  logic [arsf_pkg::NCH-1:0] clr_done;
  logic [31:0] next_prdata;

  // Is the address one of the channel result words
  function automatic logic is_chres(input logic [7:0] a);
    return (a >= arsf_pkg::OFF_CHR0) &&
      (a < arsf_pkg::OFF_CHR0 + 8'(4 * arsf_pkg::NCH));
  endfunction

  // Bus access decode; single-cycle access phase
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign rd_last = rd && paddr == arsf_pkg::OFF_LAST;
  assign rd_sr = rd && paddr == arsf_pkg::OFF_SR;
  assign rd_chres = rd && is_chres(paddr);
  assign rd_idx = 3'((paddr - arsf_pkg::OFF_CHR0) >> 2);
  assign dis_mask = (wr && paddr == arsf_pkg::OFF_CHDIS) ?
    pwdata[arsf_pkg::NCH-1:0] : '0;

  // Result kept only for a channel enabled now and not being disabled
  assign store = conv_done && ch_en[conv_ch] && !dis_mask[conv_ch];
  assign end_vec = store ? arsf_pkg::NCH'(1) << conv_ch : '0;

  // Done clears: own result read clears that channel, last-result read clears all
  always_comb begin
    clr_done = '0;
    if (rd_last)
      clr_done = '1;
    else if (rd_chres)
      clr_done[rd_idx] = 1'b1;
  end

  // Channel enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_en <= '0;
    end else if (wr && paddr == arsf_pkg::OFF_CHEN) begin
      ch_en <= ch_en | pwdata[arsf_pkg::NCH-1:0];
    end else begin
      ch_en <= ch_en & ~dis_mask;
    end
  end

  // Per-channel done and overrun flags, set wins over clear
  genvar g;
  generate
    for (g = 0; g < arsf_pkg::NCH; g++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          done_flag[g] <= 1'b0;
          channel_overrun_flag[g] <= 1'b0;
          res[g] <= '0;
        end else begin
          if (end_vec[g]) begin
            done_flag[g] <= 1'b1;
            res[g] <= conv_data;
          end else if (clr_done[g]) begin
            done_flag[g] <= 1'b0;
          end
          if (end_vec[g] && done_flag[g])
            channel_overrun_flag[g] <= 1'b1;
          else if (rd_sr)
            channel_overrun_flag[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Last result, global data-ready and global overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_result_reg <= '0;
      last_ch <= '0;
      data_ready_flag <= 1'b0;
      global_overrun_flag <= 1'b0;
    end else begin
      if (store) begin
        last_result_reg <= conv_data;
        last_ch <= conv_ch;
        data_ready_flag <= 1'b1;
      end else if (rd_last) begin
        data_ready_flag <= 1'b0;
      end
      if (store && data_ready_flag)
        global_overrun_flag <= 1'b1;
      else if (rd_sr)
        global_overrun_flag <= 1'b0;
    end
  end

  // Sleep: request armed by mode write, entered only at conversion end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_req <= 1'b0;
      sleep_active <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= wr && paddr == arsf_pkg::OFF_CTRL &&
        pwdata[arsf_pkg::BIT_START];
      if (wr && paddr == arsf_pkg::OFF_MODE)
        sleep_req <= pwdata[arsf_pkg::BIT_SLEEP];
      if (!sleep_req)
        sleep_active <= 1'b0;
      else if (conv_done)
        sleep_active <= 1'b1;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
      int_mask <= '0;
      irq <= 1'b0;
    end else begin
      for (int i = 0; i < arsf_pkg::IRQ_W; i++) begin
        if (wr && paddr == arsf_pkg::OFF_ISR && pwdata[i])
          int_stat[i] <= 1'b0;
      end
      if (store)
        int_stat[arsf_pkg::IRQ_DATA_READY_FLAG] <= 1'b1;
      if (store && data_ready_flag)
        int_stat[arsf_pkg::IRQ_GOVR] <= 1'b1;
      if (store && done_flag[conv_ch])
        int_stat[arsf_pkg::IRQ_OVR] <= 1'b1;
      if (wr && paddr == arsf_pkg::OFF_IER)
        int_mask <= pwdata[arsf_pkg::IRQ_W-1:0];
      irq <= |(int_stat & int_mask);
    end
  end

  // Read data mux
  always_comb begin
    next_prdata = '0;
    case (paddr)
      arsf_pkg::OFF_MODE: next_prdata[arsf_pkg::BIT_SLEEP] = sleep_req;
      arsf_pkg::OFF_CHSR: next_prdata[arsf_pkg::NCH-1:0] = ch_en;
      arsf_pkg::OFF_SR: begin
        next_prdata[arsf_pkg::NCH-1:0] = done_flag;
        next_prdata[arsf_pkg::SR_OVR_LSB +: arsf_pkg::NCH] =
          channel_overrun_flag;
        next_prdata[arsf_pkg::SR_DATA_READY_FLAG] = data_ready_flag;
        next_prdata[arsf_pkg::SR_GOVR] = global_overrun_flag;
        next_prdata[arsf_pkg::SR_SLEEPING] = sleep_active;
      end
      arsf_pkg::OFF_LAST: begin
        next_prdata[arsf_pkg::DW-1:0] = last_result_reg;
        next_prdata[14:12] = last_ch;
      end
      arsf_pkg::OFF_ISR: next_prdata[arsf_pkg::IRQ_W-1:0] = int_stat;
      arsf_pkg::OFF_IMR: next_prdata[arsf_pkg::IRQ_W-1:0] = int_mask;
      arsf_pkg::OFF_ID: next_prdata = arsf_pkg::ID_VALUE;
      default: begin
        if (is_chres(paddr))
          next_prdata[arsf_pkg::DW-1:0] = res[rd_idx];
      end
    endcase
  end

  // Registered APB answer: ready in the first cycle of the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= next_prdata;
      pslverr <= 1'b0;
    end
  end

  // Assertions
  a_data_ready_flag_only_last: assert property (@(posedge pclk) disable iff (!presetn)
    data_ready_flag && !store && !rd_last |=> data_ready_flag)
    else $error("data-ready lost without last-result read");
  a_data_ready_flag_needs_store: assert property (@(posedge pclk) disable iff (!presetn)
    !data_ready_flag && !store |=> !data_ready_flag)
    else $error("data-ready set without store");
  a_data_ready_flag_on_store: assert property (@(posedge pclk) disable iff (!presetn)
    store |=> data_ready_flag)
    else $error("data-ready not set on store");
  a_store_on_dis: assert property (@(posedge pclk) disable iff (!presetn)
    store && |dis_mask |=> res[$past(conv_ch)] == $past(conv_data))
    else $error("result not stored during disable");
  a_govr_set: assert property (@(posedge pclk) disable iff (!presetn)
    store && data_ready_flag |=> global_overrun_flag)
    else $error("global overrun not set");
  a_govr_clr: assert property (@(posedge pclk) disable iff (!presetn)
    rd_sr && !store |=> !global_overrun_flag)
    else $error("global overrun not cleared");
  a_govr_chread: assert property (@(posedge pclk) disable iff (!presetn)
    rd_chres && store && done_flag[conv_ch] && data_ready_flag
    |=> global_overrun_flag)
    else $error("global overrun missed on channel read");
  a_ovr_both: assert property (@(posedge pclk) disable iff (!presetn)
    |dis_mask && store && done_flag[conv_ch] && data_ready_flag
    |=> channel_overrun_flag[$past(conv_ch)] && global_overrun_flag)
    else $error("overrun flags missed on disable");
  a_done_clr: assert property (@(posedge pclk) disable iff (!presetn)
    rd_last && !store |=> done_flag == '0)
    else $error("done not cleared by last-result read");
  a_ovr_clr: assert property (@(posedge pclk) disable iff (!presetn)
    rd_sr && !store |=> channel_overrun_flag == '0)
    else $error("channel overrun not cleared");
  a_no_done_dis: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && !ch_en[conv_ch] && !done_flag[conv_ch]
    |=> !done_flag[$past(conv_ch)])
    else $error("done raised on disabled channel");
  a_done_only_own: assert property (@(posedge pclk) disable iff (!presetn)
    rd_chres && !rd_last |=> (done_flag | $past(done_flag)) ==
    ($past(done_flag) | $past(end_vec)))
    else $error("other done flag disturbed");
  a_sleep_at_end: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_active && !conv_done |=> !sleep_active)
    else $error("sleep entered without conversion end");

  // A stored conversion end
  sequence s_data_ready_flag_set;
    store;
  endsequence

  // A last-result read with no new end beside it
  sequence s_last_read;
    rd_last && !store;
  endsequence

  // Two stored ends on back-to-back edges
  sequence s_ovr_pair;
    store ##1 store;
  endsequence

  // Stored end then last-result read leaves data-ready low
  a_data_ready_flag_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    s_data_ready_flag_set ##1 s_last_read |=> !data_ready_flag)
    else $error("data-ready kept after last-result read");
  // Second end in a row always raises global overrun
  a_govr_pair: assert property (@(posedge pclk) disable iff (!presetn)
    s_ovr_pair |=> global_overrun_flag)
    else $error("global overrun missed on second end");
  // Stored end raises its channel done flag
  a_done_set: assert property (@(posedge pclk) disable iff (!presetn)
    store |=> done_flag[$past(conv_ch)])
    else $error("done not set on conversion end");
  // Stored end on a done channel raises its overrun flag
  a_ovr_chan_set: assert property (@(posedge pclk) disable iff (!presetn)
    store && done_flag[conv_ch] |=> channel_overrun_flag[$past(conv_ch)])
    else $error("channel overrun not set");
  // Channel read leaves data-ready as it was
  a_data_ready_flag_chread: assert property (@(posedge pclk) disable iff (!presetn)
    rd_chres && !store |=> data_ready_flag == $past(data_ready_flag))
    else $error("data-ready changed by channel read");
  // Last-result read beside an end on a disabled channel
  a_data_ready_flag_dis_end: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && !ch_en[conv_ch] && rd_last |=> !data_ready_flag)
    else $error("data-ready kept without stored result");
  // End during another channel's disable sets data-ready
  a_data_ready_flag_dis_set: assert property (@(posedge pclk) disable iff (!presetn)
    store && |dis_mask |=> data_ready_flag)
    else $error("data-ready missed during disable");
  // Status read beside an overrun end still sets global overrun
  a_govr_sr_end: assert property (@(posedge pclk) disable iff (!presetn)
    rd_sr && store && data_ready_flag |=> global_overrun_flag)
    else $error("global overrun lost on status read");
  // Status read with no overrun end clears global overrun
  a_govr_sr_clr: assert property (@(posedge pclk) disable iff (!presetn)
    rd_sr && !(store && data_ready_flag) |=> !global_overrun_flag)
    else $error("global overrun kept after status read");
  // Status read beside a fresh done set clears all channel overruns
  a_ovr_sr_end: assert property (@(posedge pclk) disable iff (!presetn)
    rd_sr && store && !done_flag[conv_ch] |=> channel_overrun_flag == '0)
    else $error("channel overrun kept on status read");
  // Own result read clears that channel's done flag
  a_done_chread: assert property (@(posedge pclk) disable iff (!presetn)
    rd_chres && !store |=> !done_flag[$past(rd_idx)])
    else $error("done not cleared by own result read");
  // End on a channel being disabled raises no done
  a_no_done_disw: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && dis_mask[conv_ch] && !done_flag[conv_ch]
    |=> !done_flag[$past(conv_ch)])
    else $error("done raised on channel being disabled");
  // Armed sleep begins at the conversion end
  a_sleep_enter: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_req && conv_done |=> sleep_active)
    else $error("sleep not entered at conversion end");
  // Disarmed sleep ends at once
  a_sleep_leave: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_req |=> !sleep_active)
    else $error("sleep kept after request cleared");
  // Interrupt follows unmasked status one cycle late
  a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
    |(int_stat & int_mask) |=> irq)
    else $error("interrupt not raised");
  // Interrupt falls when nothing unmasked is pending
  a_irq_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(int_stat & int_mask)) |=> !irq)
    else $error("interrupt raised without cause");
  // Ready stands for one cycle only
  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held for more than one cycle");
endmodule // arsf_top

// ### verilog/arsf_pkg.sv
// Package: register map and field layout of the converter result/status block
package arsf_pkg;
  localparam int NCH = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CHEN = 8'h10;
  localparam logic [7:0] OFF_CHDIS = 8'h14;
  localparam logic [7:0] OFF_CHSR = 8'h18;
  localparam logic [7:0] OFF_SR = 8'h1C;
  localparam logic [7:0] OFF_LAST = 8'h20;
  localparam logic [7:0] OFF_IER = 8'h24;
  localparam logic [7:0] OFF_ISR = 8'h28;
  localparam logic [7:0] OFF_IMR = 8'h2C;
  localparam logic [7:0] OFF_ID = 8'h3C;
  localparam logic [7:0] OFF_CH0 = 8'h30;
  localparam logic [7:0] OFF_CHR0 = 8'h40;
  localparam int DW = 10;
  localparam int BIT_START = 1;
  localparam int BIT_SLEEP = 5;
  localparam int SR_OVR_LSB = 8;
  localparam int SR_DATA_READY_FLAG = 16;
  localparam int SR_GOVR = 17;
  localparam int SR_SLEEPING = 18;
  localparam int IRQ_W = 3;
  localparam int IRQ_DATA_READY_FLAG = 0;
  localparam int IRQ_GOVR = 1;
  localparam int IRQ_OVR = 2;
  localparam logic [31:0] ID_VALUE = 32'h0000_0001; // Arbitrary value
endpackage

// ### verification/arsf_core_model.sv
// Converter core stand-in: runs started conversions, fires commanded ends
`timescale 1ns/1ps
module arsf_core_model #(
  parameter int LAT = 5 // Cycles from start pulse to conversion end
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Sync reset, active low
  input wire logic conv_start, // Start pulse from block
  output logic conv_done, // Conversion end pulse
  output logic [2:0] conv_ch, // Channel converted
  output logic [arsf_pkg::DW-1:0] conv_data, // Result
  output logic conv_busy // Conversion running
);
  int cnt = 0;
  // One end pulse, result derived from the channel
  task automatic pulse(input logic [2:0] ch);
    conv_done <= 1'b1;
    conv_ch <= ch;
    conv_data <= {ch, 7'h15};
  endtask
  // Quiet lines at time zero
  initial begin
    conv_done = 1'b0;
    conv_ch = 3'h0;
    conv_data = 10'h000;
    conv_busy = 1'b0;
  end
  // Ends a pulse, scrambles released lines, runs a started conversion
  always @(posedge pclk) begin
    if (conv_done) begin
      conv_done <= 1'b0;
      conv_ch <= ~conv_ch;
      conv_data <= ~conv_data;
    end
    if (!presetn) begin
      conv_busy <= 1'b0;
    end else if (conv_start && !conv_busy) begin
      conv_busy <= 1'b1;
      cnt <= LAT;
    end else if (conv_busy) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        conv_busy <= 1'b0;
        pulse(3'h1); // Conversion finishes, sleep may begin
      end
    end
  end
endmodule // arsf_core_model

// ### verification/arsf_top_tb_top.sv
// Self-checking bench for the converter result and status block
`timescale 1ns/1ps
module arsf_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, conv_done, conv_busy, conv_start, sleep_active, irq;
  logic [2:0] conv_ch;
  logic [arsf_pkg::DW-1:0] conv_data;
  int fails = 0;
  int check_count = 0;
  localparam logic [7:0] CHR1 = arsf_pkg::OFF_CHR0 + 8'h04;
  // Clock at 50 MHz
  always #10 pclk = ~pclk;
  arsf_top i_arsf_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_ch(conv_ch), .conv_data(conv_data),
    .conv_busy(conv_busy), .conv_start(conv_start),
    .sleep_active(sleep_active), .irq(irq));
  arsf_core_model i_arsf_core_model (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .conv_done(conv_done), .conv_ch(conv_ch),
    .conv_data(conv_data), .conv_busy(conv_busy));
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; f lands a conversion end of ch on its access edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic f, input logic [2:0] ch);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (f) i_arsf_core_model.pulse(ch);
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16 || pslverr !== 1'b0) fails++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare, optionally with a coinciding conversion end
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input logic f = 1'b0, input logic [2:0] ch = 3'h0);
    apb(1'b0, a, 32'h0000_0000, f, ch);
    chk(rd, e);
  endtask
  // Standalone conversion end
  task automatic fire(input logic [2:0] ch);
    @(posedge pclk);
    i_arsf_core_model.pulse(ch);
    @(posedge pclk);
  endtask
  // Status word from its fields
  function automatic logic [31:0] sr(input logic [7:0] dn, input logic [7:0] ov,
    input logic dr, input logic gv);
    return {14'h0, gv, dr, ov, dn};
  endfunction
  // Channel result word and last-result word
  function automatic logic [31:0] dv(input logic [2:0] c);
    return {22'h0, c, 7'h15};
  endfunction
  function automatic logic [31:0] lv(input logic [2:0] c);
    return {17'h0, c, 2'h0, c, 7'h15};
  endfunction
  // Reset values, identity and an unmapped place
  task automatic t_reset();
    rdc(arsf_pkg::OFF_SR, 32'h0000_0000);
    rdc(arsf_pkg::OFF_ID, arsf_pkg::ID_VALUE);
    rdc(8'h08, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask
  // Done and data-ready set and clear paths
  task automatic t_flags();
    apb(1'b1, arsf_pkg::OFF_CHEN, 32'h0000_000F, 1'b0, 3'h0);
    fire(3'h1);
    rdc(arsf_pkg::OFF_SR, sr(8'h02, 8'h00, 1'b1, 1'b0));
    rdc(arsf_pkg::OFF_CHR0, 32'h0000_0000, 1'b1, 3'h2);
    rdc(arsf_pkg::OFF_SR, sr(8'h06, 8'h00, 1'b1, 1'b1));
    rdc(CHR1, dv(3'h1));
    rdc(arsf_pkg::OFF_SR, sr(8'h04, 8'h00, 1'b1, 1'b0));
    rdc(arsf_pkg::OFF_LAST, lv(3'h2));
    rdc(arsf_pkg::OFF_SR, 32'h0000_0000);
  endtask
  // Overrun flags against reads at the same edge
  task automatic t_ovr();
    fire(3'h2);
    fire(3'h1);
    rdc(arsf_pkg::OFF_SR, sr(8'h06, 8'h00, 1'b1, 1'b1));
    rdc(arsf_pkg::OFF_CHR0, 32'h0000_0000, 1'b1, 3'h2);
    rdc(arsf_pkg::OFF_SR, sr(8'h06, 8'h04, 1'b1, 1'b1));
    fire(3'h1);
    rdc(CHR1, dv(3'h1));
    rdc(arsf_pkg::OFF_SR, sr(8'h04, 8'h02, 1'b1, 1'b1), 1'b1, 3'h1);
    rdc(arsf_pkg::OFF_SR, sr(8'h06, 8'h00, 1'b1, 1'b1));
    rdc(arsf_pkg::OFF_SR, sr(8'h06, 8'h00, 1'b1, 1'b0));
  endtask
  // Conversion ends during disables, then on a disabled channel
  task automatic t_dis();
    rdc(arsf_pkg::OFF_LAST, lv(3'h1));
    apb(1'b1, arsf_pkg::OFF_CHDIS, 32'h0000_0008, 1'b1, 3'h2);
    rdc(arsf_pkg::OFF_SR, sr(8'h04, 8'h00, 1'b1, 1'b0));
    apb(1'b1, arsf_pkg::OFF_CHDIS, 32'h0000_0001, 1'b1, 3'h2);
    rdc(arsf_pkg::OFF_SR, sr(8'h04, 8'h04, 1'b1, 1'b1));
    rdc(arsf_pkg::OFF_CHR0 + 8'h08, dv(3'h2));
    rdc(arsf_pkg::OFF_LAST, lv(3'h2), 1'b1, 3'h3);
    apb(1'b0, arsf_pkg::OFF_SR, 32'h0000_0000, 1'b0, 3'h0);
    chk(rd & 32'hFFFD_FFFF, 32'h0000_0000);
  endtask
  // Interrupt raised, masked and cleared
  task automatic t_irq();
    apb(1'b1, arsf_pkg::OFF_IER, 32'h0000_0001, 1'b0, 3'h0);
    fire(3'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, arsf_pkg::OFF_IER, 32'h0000_0000, 1'b0, 3'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b0, arsf_pkg::OFF_ISR, 32'h0000_0000, 1'b0, 3'h0);
    chk(rd & 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, arsf_pkg::OFF_ISR, 32'h0000_0007, 1'b0, 3'h0);
    rdc(arsf_pkg::OFF_ISR, 32'h0000_0000);
    rdc(arsf_pkg::OFF_IMR, 32'h0000_0000);
  endtask
  // Sleep waits for a conversion end
  task automatic t_sleep();
    int n;
    apb(1'b1, arsf_pkg::OFF_MODE, 32'h0000_0020, 1'b0, 3'h0);
    repeat (4) @(posedge pclk);
    chk({31'h0, sleep_active}, 32'h0000_0000);
    apb(1'b1, arsf_pkg::OFF_CTRL, 32'h0000_0002, 1'b0, 3'h0);
    for (n = 0; n < 20 && sleep_active !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, sleep_active}, 32'h0000_0001);
  endtask
  // Watchdog
  initial begin
    #(20 * 4000);
    fails++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_flags();
    t_ovr();
    t_dis();
    t_irq();
    t_sleep();
    conclude();
  end
endmodule // arsf_top_tb_top
